// File: pkg/sptc_pkg.sv
// constants, types and decode shared by the power/time-out control block
package sptc_pkg;

   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_SOFT_RESET = 12'h460;
   localparam logic [11:0] IDX_RSVD_A     = 12'h46C;
   localparam logic [11:0] IDX_PULLDOWN   = 12'h46E;
   localparam logic [11:0] IDX_POWER_SAVE = 12'h470;
   localparam logic [11:0] IDX_TIMEOUT    = 12'h472;
   localparam logic [11:0] IDX_RSVD_B     = 12'h4A0;
   localparam logic [11:0] IDX_RSVD_C     = 12'h4A2;

   // reset values and the software reset key
   localparam logic [15:0] RST_SOFT_RESET = 16'h0000;
   localparam logic [15:0] RST_PULLDOWN   = 16'h0000;
   localparam logic [15:0] RST_POWER_SAVE = 16'h0001;
   localparam logic [15:0] RST_TIMEOUT    = 16'h0001;
   localparam logic [15:0] SOFT_RESET_KEY = 16'hA55A;

   // field positions and widths
   localparam int STRAP_W        = 9;
   localparam int PS_EN_BIT      = 0;
   localparam int TO_DIS_BIT     = 0;
   localparam int TO_IRQ_DIS_BIT = 1;
   localparam int TO_FLAG_BIT    = 2;
   localparam int SEL_HI_BIT     = 8;
   localparam int SEL_LO_BIT     = 7;

   // time-out thresholds in reference clock edges
   localparam int          LIMIT_W   = 12;
   localparam logic [11:0] TO_LIMIT0 = 12'h800;
   localparam logic [11:0] TO_LIMIT1 = 12'hA00;
   localparam logic [11:0] TO_LIMIT2 = 12'hC00;

   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum {
      sptc_reg_none, sptc_reg_soft, sptc_reg_rsvd,
      sptc_reg_pd, sptc_reg_ps, sptc_reg_to
   } sptc_reg_t;

   typedef enum {sptc_to_idle, sptc_to_release, sptc_to_reset} sptc_to_t;

   function automatic sptc_reg_t sptc_decode(input logic [15:0] a);
      sptc_reg_t r;
      r = sptc_reg_none;
      if (a[1:0] != 2'h0 || a[15:14] != 2'h0) begin
         r = sptc_reg_none;
      end else if (a[13:2] == IDX_SOFT_RESET) begin
         r = sptc_reg_soft;
      end else if (a[13:2] == IDX_PULLDOWN) begin
         r = sptc_reg_pd;
      end else if (a[13:2] == IDX_POWER_SAVE) begin
         r = sptc_reg_ps;
      end else if (a[13:2] == IDX_TIMEOUT) begin
         r = sptc_reg_to;
      end else if (a[13:2] == IDX_RSVD_A || a[13:2] == IDX_RSVD_B ||
                   a[13:2] == IDX_RSVD_C) begin
         r = sptc_reg_rsvd;
      end
      return r;
   endfunction : sptc_decode

endpackage : sptc_pkg

// File: rtl/sptc_strap_latch.sv
// captures the strap pin levels once after reset release
module sptc_strap_latch
   import sptc_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic               nrst,
   input  wire logic               clk_en,
   input  wire logic [STRAP_W-1:0] pins,
   output logic      [STRAP_W-1:0] captured
);
   logic taken;

   // taken in the first enabled cycle after release, then frozen
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         taken    <= 1'b0;
         captured <= '0;
      end else if (clk_en && !taken) begin
         taken    <= 1'b1;
         captured <= pins;
      end
   end
endmodule : sptc_strap_latch

// File: rtl/sptc_ref_timer.sv
// counts reference clock edges while the host wait is held
module sptc_ref_timer
   import sptc_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       clk_en,
   input  wire logic       run,
   input  wire logic       ref_clk,
   input  wire logic [1:0] sel,
   output logic            expired
);
   logic [LIMIT_W-1:0] count;
   logic [LIMIT_W-1:0] limit;
   logic               ref_q;

   always_comb begin
      case (sel)
         2'h0:    limit = TO_LIMIT0;
         2'h1:    limit = TO_LIMIT1;
         default: limit = TO_LIMIT2;
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ref_q   <= 1'b0;
         count   <= '0;
         expired <= 1'b0;
      end else if (clk_en) begin
         ref_q   <= ref_clk;
         expired <= 1'b0;
         if (!run) begin
            count <= '0;
         end else if (ref_clk && !ref_q) begin
            if (count == limit - 12'h001) begin
               count   <= '0;
               expired <= 1'b1;
            end else begin
               count <= count + 12'h001;
            end
         end
      end
   end
endmodule : sptc_ref_timer

// File: rtl/sptc_top.sv
// strap pull-down control, power save and host bus time-out reset
module sptc_top
   import sptc_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic               nrst,
   input  wire logic               clk_en,
   input  wire logic [15:0]        s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [15:0]        s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic [STRAP_W-1:0] config_strap_pins,
   input  wire logic               primary_pll_ref,
   input  wire logic               host_wait_active,
   output logic      [STRAP_W-1:0] strap_config,
   output logic      [STRAP_W-1:0] strap_pulldown_dis,
   output logic                    io_clk_run,
   output logic                    host_wait_release,
   output logic                    device_reset,
   output logic                    irq
);

   // write channel holding state
   logic [15:0] aw_addr;
   logic        aw_have;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        w_have;
   logic        wr_fire;
   sptc_reg_t   wr_reg;
   sptc_reg_t   rd_reg;

   // register contents
   logic [15:0]        soft_reset_val;
   logic [STRAP_W-1:0] pulldown_ctrl;
   logic               ps_en;
   logic               to_dis;
   logic               to_irq_dis;
   logic               to_flag;

   // time-out sequencing
   sptc_to_t    to_state;
   sptc_to_t    next_to_state;
   logic        timer_run;
   logic        timer_expired;
   logic        sync_clear;
   logic        key_hit;
   logic        to_flag_set;
   logic        to_flag_clr;
   logic [15:0] wr_val;
   logic [15:0] rd_val;
   logic [STRAP_W-1:0] strap_latched;

   // merge a 16-bit register with the two low byte lanes
   function automatic logic [15:0] lane_merge(
      input logic [15:0] old,
      input logic [31:0] data,
      input logic [3:0]  strb
   );
      logic [15:0] v;
      v = old;
      if (strb[0]) begin
         v[7:0] = data[7:0];
      end
      if (strb[1]) begin
         v[15:8] = data[15:8];
      end
      return v;
   endfunction : lane_merge

   // current value of a register as read by software
   function automatic logic [15:0] reg_image(input sptc_reg_t r);
      logic [15:0] v;
      v = 16'h0000;
      if (r == sptc_reg_soft) begin
         v = soft_reset_val;
      end else if (r == sptc_reg_pd) begin
         v[STRAP_W-1:0] = pulldown_ctrl;
      end else if (r == sptc_reg_ps) begin
         v[PS_EN_BIT] = ps_en;
      end else if (r == sptc_reg_to) begin
         v[TO_DIS_BIT]     = to_dis;
         v[TO_IRQ_DIS_BIT] = to_irq_dis;
         v[TO_FLAG_BIT]    = to_flag;
      end
      return v;
   endfunction : reg_image

   // strap capture happens once; later pull-down changes do not touch it
   sptc_strap_latch u_strap (
      .mclk     (mclk),
      .nrst     (nrst),
      .clk_en   (clk_en),
      .pins     (config_strap_pins),
      .captured (strap_latched)
   );

   sptc_ref_timer u_timer (
      .mclk    (mclk),
      .nrst    (nrst),
      .clk_en  (clk_en),
      .run     (timer_run),
      .ref_clk (primary_pll_ref),
      .sel     (strap_latched[SEL_HI_BIT:SEL_LO_BIT]),
      .expired (timer_expired)
   );

   // decode and data for the pending write and for the current read address
   always_comb begin
      wr_fire = aw_have && w_have && !s_axi_bvalid;
      wr_reg  = sptc_decode(aw_addr);
      rd_reg  = sptc_decode(s_axi_araddr);
      wr_val  = lane_merge(reg_image(wr_reg), w_data, w_strb);
      rd_val  = reg_image(rd_reg);
   end

   // key write and time-out reset share one clearing path
   always_comb begin
      key_hit    = wr_fire && wr_reg == sptc_reg_soft &&
                   wr_val == SOFT_RESET_KEY;
      sync_clear = key_hit || to_state == sptc_to_reset;
   end

   // write address channel
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s_axi_awready <= 1'b1;
         aw_have       <= 1'b0;
         aw_addr       <= 16'h0000;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_have       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
            aw_have       <= 1'b0;
         end
      end
   end

   // write data channel
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s_axi_wready <= 1'b1;
         w_have       <= 1'b0;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
      end else if (clk_en) begin
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_have       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
            w_have       <= 1'b0;
         end
      end
   end

   // write response; reserved words accept and drop the data
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (clk_en) begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (wr_reg == sptc_reg_none) begin
               s_axi_bresp <= RESP_SLVERR;
            end else begin
               s_axi_bresp <= RESP_OKAY;
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel; access in power save is not blocked, host avoids it
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {16'h0000, rd_val};
            if (rd_reg == sptc_reg_none) begin
               s_axi_rresp <= RESP_SLVERR;
            end else begin
               s_axi_rresp <= RESP_OKAY;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // software reset register; the key itself never reads back
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         soft_reset_val <= RST_SOFT_RESET;
      end else if (clk_en) begin
         if (sync_clear) begin
            soft_reset_val <= RST_SOFT_RESET;
         end else if (wr_fire && wr_reg == sptc_reg_soft) begin
            soft_reset_val <= wr_val;
         end
      end
   end

   // pull-down control, one bit per strap pin
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pulldown_ctrl <= RST_PULLDOWN[STRAP_W-1:0];
      end else if (clk_en) begin
         if (sync_clear) begin
            pulldown_ctrl <= RST_PULLDOWN[STRAP_W-1:0];
         end else if (wr_fire && wr_reg == sptc_reg_pd) begin
            pulldown_ctrl <= wr_val[STRAP_W-1:0];
         end
      end
   end

   // power save enable; comes out of reset set
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ps_en <= RST_POWER_SAVE[PS_EN_BIT];
      end else if (clk_en) begin
         if (sync_clear) begin
            ps_en <= RST_POWER_SAVE[PS_EN_BIT];
         end else if (wr_fire && wr_reg == sptc_reg_ps) begin
            ps_en <= wr_val[PS_EN_BIT];
         end
      end
   end

   // time-out control bits
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         to_dis     <= RST_TIMEOUT[TO_DIS_BIT];
         to_irq_dis <= RST_TIMEOUT[TO_IRQ_DIS_BIT];
      end else if (clk_en) begin
         if (sync_clear) begin
            to_dis     <= RST_TIMEOUT[TO_DIS_BIT];
            to_irq_dis <= RST_TIMEOUT[TO_IRQ_DIS_BIT];
         end else if (wr_fire && wr_reg == sptc_reg_to) begin
            to_dis     <= wr_val[TO_DIS_BIT];
            to_irq_dis <= wr_val[TO_IRQ_DIS_BIT];
         end
      end
   end

   // flag must outlive the reset it reports, so the time-out clear
   // path leaves it alone and sets it instead
   always_comb begin
      to_flag_set = to_state == sptc_to_reset;
      to_flag_clr = key_hit || (wr_fire && wr_reg == sptc_reg_to &&
                    wr_val[TO_IRQ_DIS_BIT]);
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         to_flag <= 1'b0;
      end else if (clk_en) begin
         if (to_flag_set) begin
            to_flag <= 1'b1;
         end else if (to_flag_clr) begin
            to_flag <= 1'b0;
         end
      end
   end

   // count only while the host wait is held and the function is on
   always_comb begin
      timer_run = host_wait_active && !to_dis &&
                  to_state == sptc_to_idle;
   end

   always_comb begin
      next_to_state = to_state;
      case (to_state)
         sptc_to_idle: begin
            if (timer_expired) begin
               next_to_state = sptc_to_release;
            end
         end
         sptc_to_release: begin
            next_to_state = sptc_to_reset;
         end
         sptc_to_reset: begin
            next_to_state = sptc_to_idle;
         end
         default: begin
            next_to_state = sptc_to_idle;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         to_state <= sptc_to_idle;
      end else if (clk_en) begin
         to_state <= next_to_state;
      end
   end

   // wait release leads the reset pulse by two cycles
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         host_wait_release <= 1'b0;
         device_reset      <= 1'b0;
      end else if (clk_en) begin
         host_wait_release <= next_to_state == sptc_to_release;
         device_reset      <= sync_clear;
      end
   end

   // registered outputs; irq lags the flag by one cycle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irq                <= 1'b0;
         io_clk_run         <= 1'b0;
         strap_pulldown_dis <= '0;
         strap_config       <= '0;
      end else if (clk_en) begin
         irq                <= to_flag && !to_irq_dis;
         io_clk_run         <= !ps_en;
         strap_pulldown_dis <= pulldown_ctrl;
         strap_config       <= strap_latched;
      end
   end

endmodule : sptc_top

// File: test/sptc_top_sva.sv
// port assertions for the power save and bus time-out block
module sptc_top_sva
   import sptc_pkg::*;
(
   input wire logic               mclk,
   input wire logic               nrst,
   input wire logic [15:0]        s_axi_awaddr,
   input wire logic               s_axi_awvalid,
   input wire logic               s_axi_awready,
   input wire logic [31:0]        s_axi_wdata,
   input wire logic [3:0]         s_axi_wstrb,
   input wire logic               s_axi_wvalid,
   input wire logic               s_axi_wready,
   input wire logic [STRAP_W-1:0] strap_config,
   input wire logic [STRAP_W-1:0] strap_pulldown_dis,
   input wire logic               io_clk_run,
   input wire logic               host_wait_release,
   input wire logic               device_reset,
   input wire logic               irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   // straps settle on the second edge, so hold is checked from the fourth
   logic [2:0] age;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         age <= 3'h0;
      end else if (age != 3'h4) begin
         age <= age + 3'h1;
      end
   end

   sequence s_wr(logic [15:0] a);
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      s_axi_awaddr == a && s_axi_wstrb[1:0] == 2'h3;
   endsequence
   // irq is registered off the flag, so it trails the reset pulse
   sequence s_rel_to_rst;
      host_wait_release ##1 !device_reset ##1 device_reset ##1 irq;
   endsequence

   property p_pd_write;
      s_wr(16'h11B8) |=> ##2 strap_pulldown_dis == $past(s_axi_wdata[8:0], 3);
   endproperty
   property p_strap_hold;
      age == 3'h4 |-> $stable(strap_config);
   endproperty
   property p_ps_write;
      s_wr(16'h11C0) |=> ##2 io_clk_run == !$past(s_axi_wdata[0], 3);
   endproperty
   // io run output is registered off the cleared bit, one cycle later
   property p_rst_default;
      device_reset |=> !io_clk_run;
   endproperty
   property p_to_seq;
      host_wait_release |-> s_rel_to_rst;
   endproperty
   property p_rel_pulse;
      host_wait_release |=> !host_wait_release;
   endproperty
   property p_mask;
      s_wr(16'h11C8) ##0 s_axi_wdata[1] |=> ##2 !irq;
   endproperty
   property p_key;
      s_wr(16'h1180) ##0 s_axi_wdata[15:0] == SOFT_RESET_KEY
         |-> ##[2:4] device_reset;
   endproperty

   a_pd_write: assert property (p_pd_write)
      else $error("pull-down outputs differ from written bits");
   a_strap_hold: assert property (p_strap_hold)
      else $error("captured straps changed after capture");
   a_ps_write: assert property (p_ps_write)
      else $error("io clock run does not follow power save bit");
   a_rst_default: assert property (p_rst_default)
      else $error("power save not back on at core reset");
   a_to_seq: assert property (p_to_seq)
      else $error("release not followed by reset and irq");
   a_rel_pulse: assert property (p_rel_pulse)
      else $error("wait release longer than one cycle");
   a_mask: assert property (p_mask)
      else $error("irq still high after interrupt disable");
   a_key: assert property (p_key)
      else $error("no core reset after key write");
endmodule : sptc_top_sva

bind sptc_top sptc_top_sva i_sva (.*);

// File: test/sptc_host_model.sv
// host bus master issuing single register accesses
module sptc_host_model
(
   input  wire logic        mclk,
   output logic      [15:0] s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic      [31:0] s_axi_wdata,
   output logic      [3:0]  s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic      [15:0] s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr} = 32'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
   end

   // st delays the response ready, to act as a slow host
   task automatic wr(input logic [15:0] a, input logic [15:0] d,
                     input int st, output logic [1:0] resp);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_wstrb <= 4'h3;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) ||
                 (s_axi_wvalid && !s_axi_wready));
      s_axi_wdata <= ~s_axi_wdata;
      repeat (st) @(posedge mclk);
      s_axi_bready <= 1'b1;
      do @(posedge mclk); while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] a, input int st,
                     output logic [31:0] d, output logic [1:0] resp);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge mclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      repeat (st) @(posedge mclk);
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : sptc_host_model

// File: test/sptc_top_tb.sv
// self-checking bench for the power save and bus time-out block
module sptc_top_tb import sptc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic               mclk, nrst, clk_en;
   logic [15:0]        s_axi_awaddr, s_axi_araddr;
   logic [31:0]        s_axi_wdata, s_axi_rdata;
   logic [3:0]         s_axi_wstrb;
   logic [1:0]         s_axi_bresp, s_axi_rresp;
   logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic               s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic               s_axi_rready, primary_pll_ref, host_wait_active;
   logic [STRAP_W-1:0] config_strap_pins, strap_config, strap_pulldown_dis;
   logic               io_clk_run, host_wait_release, device_reset, irq;
   int                 n_mismatch, num_checks, n_rel, n_rst;

   sptc_top i_dut (.*);
   sptc_host_model i_host (.*);

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (host_wait_release === 1'b1) n_rel++;
      if (device_reset === 1'b1) n_rst++;
   end

   task automatic chk(input string what, input logic [33:0] e,
                      input logic [33:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic rdc(input logic [15:0] a, input logic [15:0] e,
                      input int st = 0);
      logic [31:0] d;
      logic [1:0]  r;
      i_host.rd(a, st, d, r);
      chk($sformatf("read %h", a), {RESP_OKAY, 16'h0, e}, {r, d});
   endtask : rdc
   task automatic wrs(input logic [15:0] a, input logic [15:0] d,
                      input logic [1:0] er = RESP_OKAY);
      logic [1:0] r;
      i_host.wr(a, d, 2, r);
      chk($sformatf("bresp %h", a), 34'(er), 34'(r));
      repeat (4) @(posedge mclk);
      #1;
   endtask : wrs

   task automatic t_defaults;
      repeat (3) @(posedge mclk);
      #1;
      chk("strap", 34'(9'h180), 34'(strap_config));
      chk("io run", 34'h0, 34'(io_clk_run));
      chk("pd out", 34'h0, 34'(strap_pulldown_dis));
      rdc(16'h11C0, RST_POWER_SAVE);
      wrs(16'h11C0, 16'h0000); // leave power save first
      chk("io run", 34'h1, 34'(io_clk_run));
      rdc(16'h11B8, RST_PULLDOWN);
      rdc(16'h11C8, RST_TIMEOUT);
      config_strap_pins <= 9'h055;
      wrs(16'h11B8, 16'h01A5);
      chk("pd out", 34'(9'h1A5), 34'(strap_pulldown_dis));
      rdc(16'h11B8, 16'h01A5, 3);
      chk("strap", 34'(9'h180), 34'(strap_config));
   endtask : t_defaults

   task automatic t_decode;
      rdc(16'h11B0, 16'h0000); // reserved words only read
      rdc(16'h1288, 16'h0000);
      wrs(16'h0004, 16'h1234, RESP_SLVERR);
      wrs(16'h11B9, 16'h0000, RESP_SLVERR);
      chk("pd out", 34'(9'h1A5), 34'(strap_pulldown_dis));
   endtask : t_decode

   task automatic t_soft;
      wrs(16'h1180, 16'h1234);
      rdc(16'h1180, 16'h1234);
      wrs(16'h11C8, 16'h0002);
      wrs(16'h1180, SOFT_RESET_KEY);
      chk("resets", 34'h1, 34'(n_rst));
      chk("io run", 34'h0, 34'(io_clk_run));
      rdc(16'h11C0, RST_POWER_SAVE);
      wrs(16'h11C0, 16'h0000);
      chk("pd out", 34'h0, 34'(strap_pulldown_dis));
      rdc(16'h11C8, RST_TIMEOUT);
      rdc(16'h1180, RST_SOFT_RESET);
   endtask : t_soft

   task automatic t_timeout;
      wrs(16'h11C8, 16'h0000);
      @(posedge mclk);
      host_wait_active <= 1'b1;
      // strap bits 8:7 high select the longest threshold
      for (int i = 0; i < 3072; i++) begin
         if (i == 3071) begin
            repeat (8) @(posedge mclk);
            chk("early release", 34'h0, 34'(n_rel));
         end
         @(posedge mclk);
         primary_pll_ref <= 1'b1;
         @(posedge mclk);
         primary_pll_ref <= 1'b0;
      end
      repeat (10) @(posedge mclk);
      #1;
      chk("release", 34'h1, 34'(n_rel));
      chk("resets", 34'h2, 34'(n_rst));
      chk("irq", 34'h1, 34'(irq));
      @(posedge mclk);
      host_wait_active <= 1'b0;
      rdc(16'h11C0, RST_POWER_SAVE);
      wrs(16'h11C0, 16'h0000);
      rdc(16'h11C8, RST_TIMEOUT | 16'h0004);
      wrs(16'h11C8, 16'h0003);
      chk("irq", 34'h0, 34'(irq));
      rdc(16'h11C8, 16'h0003);
      wrs(16'h11C8, 16'h0001);
      chk("irq", 34'h0, 34'(irq));
   endtask : t_timeout

   task results;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   initial begin
      {n_mismatch, num_checks, n_rel, n_rst} = 128'h0;
      nrst = 1'b0;
      clk_en = 1'b1;
      config_strap_pins = 9'h180;
      primary_pll_ref = 1'b0;
      host_wait_active = 1'b0;
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      t_defaults();
      t_decode();
      t_soft();
      t_timeout();
      results();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      results();
   end
endmodule : sptc_top_tb
